// ### rtl/reset_controller_end.sv
// Controller end: runs the reset sequences onto the cluster's reset lines
// ==========================================================
// What this block does
// RULE1 - Four-bit vector selects target core
// RULE2 - Shared resets only for cluster resets
// RULE3 - Cluster power-on initialises everything
// RULE4 - Power-on reset at first power
// RULE5 - Release synchronous, clocks gated around it
// RULE6 - Hold resets at least nine cycles
// RULE7 - Power-on asserts all six resets
// RULE8 - Hold fifteen cycles recommended
// RULE9 - Gate clocks while resets held
// RULE10 - Wait ten, release, wait ten, ungate
// RULE11 - Cluster software reset spares debug
// RULE12 - Software sequence skips debug resets
// RULE13 - Per-core power-on resets core n
// RULE14 - Per-core resets, watchdog optional
// RULE15 - Per-core sequence uses same timing
// RULE16 - Per-core software reset skips debug
// RULE17 - SIMD reset uses SIMD lines only
// RULE18 - SIMD reset needs own power domain
// RULE19 - Cluster debug reset, clocks ungated
// RULE20 - Single-core debug reset, clocks ungated
// RULE21 - Watchdog reset clears one flag
// RULE22 - Peripheral enable at ratio two+
// RULE23 - Counts configurable, SIMD steps optional
`timescale 1ns/1ps
`include "reset_seq_defines.svh"

module reset_controller_end #(
    parameter bit SIMD_PRESENT = 1'b1,
    parameter int HOLD_CYCLES = `HOLD_CYCLES,
    parameter int SETTLE_CYCLES = `SETTLE_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Request
    input wire logic reqValid,
    input wire reset_seq_pkg::reset_kind_type reqKind,
    input wire logic [`NUM_CORES-1:0] reqCore,
    input wire logic reqWdog,
    output logic busy_ff,
    output logic done_ff,
    // Link
    reset_link_if.sequencer link
);
    localparam logic [`CNT_W-1:0] HOLD_LAST =
        `CNT_W'((HOLD_CYCLES < `MIN_HOLD_CYCLES ? `MIN_HOLD_CYCLES : HOLD_CYCLES) - 1);
    localparam logic [`CNT_W-1:0] SETTLE_LAST = `CNT_W'(SETTLE_CYCLES - 1);
    localparam logic [`CNT_W-1:0] PULSE_LAST = `CNT_W'(`DEBUG_PULSE_CYCLES - 1);
    localparam logic [`NUM_CORES-1:0] ALL = {`NUM_CORES{1'b1}};

    reset_seq_pkg::seq_state_type state_ff;
    reset_seq_pkg::reset_kind_type kind_ff;
    logic [`NUM_CORES-1:0] sel_ff;
    logic [`CNT_W-1:0] cnt_ff;
    logic [`PDIV_W-1:0] pdiv_ff;
    logic [`NUM_CORES-1:0] coreRstN_ff, simdRstN_ff, dbgRstN_ff, wdRstN_ff, coreGate_ff, simdGate_ff;
    logic sharedRstN_ff, pclkEn_ff;

    // ==========================================================
    // Which lines a kind touches (active high masks)
    // RULE1 - Vector bit n selects core n
    function automatic logic [`NUM_CORES-1:0] tgt(input reset_seq_pkg::reset_kind_type k,
                                                 input logic [`NUM_CORES-1:0] s);
        tgt = (k == reset_seq_pkg::KIND_CLUSTER_POR || k == reset_seq_pkg::KIND_CLUSTER_SW ||
               k == reset_seq_pkg::KIND_CLUSTER_DBG) ? ALL : s;
    endfunction : tgt

    function automatic logic [`NUM_CORES-1:0] coreMask(input reset_seq_pkg::reset_kind_type k,
                                                      input logic [`NUM_CORES-1:0] s);
        // RULE16 - Software resets reset functional logic
        case (k)
            reset_seq_pkg::KIND_CLUSTER_POR, reset_seq_pkg::KIND_CLUSTER_SW,
            reset_seq_pkg::KIND_CORE_POR, reset_seq_pkg::KIND_CORE_SW: coreMask = tgt(k, s);
            default: coreMask = '0;
        endcase
    endfunction : coreMask

    function automatic logic [`NUM_CORES-1:0] simdMask(input reset_seq_pkg::reset_kind_type k,
                                                      input logic [`NUM_CORES-1:0] s);
        // RULE17 - SIMD reset touches SIMD lines only
        // RULE23 - SIMD steps skipped when absent
        if (!SIMD_PRESENT) begin
            simdMask = '0;
        end else if (k == reset_seq_pkg::KIND_SIMD_POR) begin
            simdMask = s;
        end else begin
            simdMask = coreMask(k, s);
        end
    endfunction : simdMask

    function automatic logic [`NUM_CORES-1:0] dbgMask(input reset_seq_pkg::reset_kind_type k,
                                                     input logic [`NUM_CORES-1:0] s);
        // RULE12 - Software resets never touch debug
        case (k)
            reset_seq_pkg::KIND_CLUSTER_POR, reset_seq_pkg::KIND_CORE_POR,
            reset_seq_pkg::KIND_CLUSTER_DBG, reset_seq_pkg::KIND_CORE_DBG: dbgMask = tgt(k, s);
            default: dbgMask = '0;
        endcase
    endfunction : dbgMask

    function automatic logic [`NUM_CORES-1:0] wdMask(input reset_seq_pkg::reset_kind_type k,
                                                    input logic [`NUM_CORES-1:0] s,
                                                    input logic w);
        // RULE14 - Per-core watchdog reset is optional
        case (k)
            reset_seq_pkg::KIND_CLUSTER_POR, reset_seq_pkg::KIND_CLUSTER_SW: wdMask = ALL;
            reset_seq_pkg::KIND_CORE_POR, reset_seq_pkg::KIND_CORE_SW: wdMask = w ? s : '0;
            reset_seq_pkg::KIND_WDOG: wdMask = s;
            default: wdMask = '0;
        endcase
    endfunction : wdMask

    // RULE2 - Shared resets only for cluster resets
    function automatic logic isCluster(input reset_seq_pkg::reset_kind_type k);
        isCluster = (k == reset_seq_pkg::KIND_CLUSTER_POR || k == reset_seq_pkg::KIND_CLUSTER_SW);
    endfunction : isCluster

    function automatic logic isPulse(input reset_seq_pkg::reset_kind_type k);
        isPulse = (k == reset_seq_pkg::KIND_CLUSTER_DBG || k == reset_seq_pkg::KIND_CORE_DBG ||
                   k == reset_seq_pkg::KIND_WDOG);
    endfunction : isPulse

    // ==========================================================
    // Sequence state
    // RULE4 - Power-on reset runs out of system reset
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_ff <= reset_seq_pkg::ST_HOLD;
            kind_ff <= reset_seq_pkg::KIND_CLUSTER_POR;
            sel_ff <= ALL;
            cnt_ff <= '0;
        end else begin
            case (state_ff)
                reset_seq_pkg::ST_IDLE: begin
                    cnt_ff <= '0;
                    if (reqValid) begin
                        kind_ff <= reqKind;
                        sel_ff <= reqCore;
                        state_ff <= isPulse(reqKind) ? reset_seq_pkg::ST_PULSE : reset_seq_pkg::ST_HOLD;
                    end
                end
                // RULE6 - Hold at least nine cycles
                // RULE8 - Fifteen by default
                reset_seq_pkg::ST_HOLD: begin
                    cnt_ff <= (cnt_ff == HOLD_LAST) ? '0 : cnt_ff + 1'b1;
                    if (cnt_ff == HOLD_LAST) begin
                        state_ff <= reset_seq_pkg::ST_GATE;
                    end
                end
                // RULE10 - Settle ten, release, settle ten
                reset_seq_pkg::ST_GATE: begin
                    cnt_ff <= (cnt_ff == SETTLE_LAST) ? '0 : cnt_ff + 1'b1;
                    if (cnt_ff == SETTLE_LAST) begin
                        state_ff <= reset_seq_pkg::ST_RELEASE;
                    end
                end
                reset_seq_pkg::ST_RELEASE: begin
                    cnt_ff <= (cnt_ff == SETTLE_LAST) ? '0 : cnt_ff + 1'b1;
                    if (cnt_ff == SETTLE_LAST) begin
                        state_ff <= reset_seq_pkg::ST_UNGATE;
                    end
                end
                // RULE19 - Debug and watchdog pulses, no gating
                reset_seq_pkg::ST_PULSE: begin
                    cnt_ff <= (cnt_ff == PULSE_LAST) ? '0 : cnt_ff + 1'b1;
                    if (cnt_ff == PULSE_LAST) begin
                        state_ff <= reset_seq_pkg::ST_UNGATE;
                    end
                end
                default: begin
                    state_ff <= reset_seq_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Line drive, held active low like the pins
    // RULE7 - All six resets in power-on
    // RULE5 - Hold-sequence release only while clocks are gated; pulses release ungated
    // RULE20 - Debug pulse leaves gates off
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            coreRstN_ff <= '0;
            dbgRstN_ff <= '0;
            wdRstN_ff <= '0;
            sharedRstN_ff <= 1'b0;
            simdRstN_ff <= '0;
        end else if (state_ff == reset_seq_pkg::ST_IDLE && reqValid) begin
            coreRstN_ff <= ~coreMask(reqKind, reqCore);
            simdRstN_ff <= ~simdMask(reqKind, reqCore);
            dbgRstN_ff <= ~dbgMask(reqKind, reqCore);
            wdRstN_ff <= ~wdMask(reqKind, reqCore, reqWdog);
            sharedRstN_ff <= !isCluster(reqKind);
        end else if ((state_ff == reset_seq_pkg::ST_GATE && cnt_ff == SETTLE_LAST) ||
                     (state_ff == reset_seq_pkg::ST_PULSE && cnt_ff == PULSE_LAST)) begin
            coreRstN_ff <= ALL;
            simdRstN_ff <= ALL;
            dbgRstN_ff <= ALL;
            wdRstN_ff <= ALL;
            sharedRstN_ff <= 1'b1;
        end
    end

    // RULE9 - Gate clocks after the hold
    // RULE15 - Per-core gating uses index n only
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            coreGate_ff <= '0;
            simdGate_ff <= '0;
        end else if (state_ff == reset_seq_pkg::ST_HOLD && cnt_ff == HOLD_LAST) begin
            coreGate_ff <= coreMask(kind_ff, sel_ff);
            simdGate_ff <= simdMask(kind_ff, sel_ff);
        end else if (state_ff == reset_seq_pkg::ST_RELEASE && cnt_ff == SETTLE_LAST) begin
            coreGate_ff <= '0;
            simdGate_ff <= '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        busy_ff <= sys_rst || state_ff != reset_seq_pkg::ST_IDLE;
        done_ff <= !sys_rst && state_ff == reset_seq_pkg::ST_UNGATE;
    end

    // RULE22 - Peripheral enable one in PERIPH_RATIO
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pdiv_ff <= '0;
            pclkEn_ff <= 1'b0;
        end else begin
            pdiv_ff <= (pdiv_ff == `PDIV_W'(`PERIPH_RATIO - 1)) ? '0 : pdiv_ff + 1'b1;
            pclkEn_ff <= (pdiv_ff == `PDIV_W'(`PERIPH_RATIO - 1));
        end
    end

    assign link.core_rst_n = coreRstN_ff;
    assign link.simd_engine_rst_n = simdRstN_ff;
    assign link.debug_logic_rst_n = dbgRstN_ff;
    assign link.watchdog_flag_rst_n = wdRstN_ff;
    assign link.snoop_unit_rst_n = sharedRstN_ff;
    assign link.periph_block_rst_n = sharedRstN_ff;
    assign link.core_clock_gate = coreGate_ff;
    assign link.simd_clock_gate = simdGate_ff;
    assign link.peripheral_clock_en = pclkEn_ff;
endmodule : reset_controller_end

// ### pkg/reset_seq_defines.svh
// Timing counts and constants shared by the reset sequencer ends
`ifndef RESET_SEQ_DEFINES_SVH
`define RESET_SEQ_DEFINES_SVH

// ==========================================================
// Widths
`define NUM_CORES 4
// ==========================================================
// Timing in main-clock cycles
`define CLK_PERIOD_NS 10
`define MIN_HOLD_CYCLES 9
`define HOLD_CYCLES 15
`define SETTLE_CYCLES 10
`define DEBUG_PULSE_CYCLES 4
`define CNT_W 5
// ==========================================================
// Peripheral clock-enable ratio, at least two
`define PERIPH_RATIO 2
`define PDIV_W 4

`endif

// ### pkg/reset_seq_pkg.sv
// Types for the reset sequencer
package reset_seq_pkg;

    // Reset kinds the controller can be asked to run
    typedef enum logic [2:0] {
        KIND_CLUSTER_POR,
        KIND_CLUSTER_SW,
        KIND_CORE_POR,
        KIND_CORE_SW,
        KIND_SIMD_POR,
        KIND_CLUSTER_DBG,
        KIND_CORE_DBG,
        KIND_WDOG
    } reset_kind_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HOLD,
        ST_GATE,
        ST_RELEASE,
        ST_UNGATE,
        ST_PULSE
    } seq_state_type;

endpackage : reset_seq_pkg

// ### pkg/reset_link_if.sv
// Reset and clock-gate wires between the sequencer and the cluster
`timescale 1ns/1ps
`include "reset_seq_defines.svh"

interface reset_link_if;
    logic snoop_unit_rst_n;
    logic periph_block_rst_n;
    logic [`NUM_CORES-1:0] core_rst_n;
    logic [`NUM_CORES-1:0] simd_engine_rst_n;
    logic [`NUM_CORES-1:0] debug_logic_rst_n;
    logic [`NUM_CORES-1:0] watchdog_flag_rst_n;
    logic [`NUM_CORES-1:0] core_clock_gate;
    logic [`NUM_CORES-1:0] simd_clock_gate;
    logic peripheral_clock_en;

    modport sequencer (
        output snoop_unit_rst_n, periph_block_rst_n, core_rst_n, simd_engine_rst_n,
        output debug_logic_rst_n, watchdog_flag_rst_n, core_clock_gate, simd_clock_gate,
        output peripheral_clock_en
    );
    modport cluster (
        input snoop_unit_rst_n, periph_block_rst_n, core_rst_n, simd_engine_rst_n,
        input debug_logic_rst_n, watchdog_flag_rst_n, core_clock_gate, simd_clock_gate,
        input peripheral_clock_en
    );
endinterface : reset_link_if

// ### rtl/core_reset_slice.sv
// One core's view of the reset lines: which parts are being initialised
`timescale 1ns/1ps

module core_reset_slice (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Reset lines for this core
    input wire logic snoopRstN,
    input wire logic coreRstN,
    input wire logic simdRstN,
    input wire logic debugRstN,
    input wire logic wdogRstN,
    input wire logic coreGate,
    input wire logic simdGate,
    // Per-core state
    input wire logic wdogFire,
    output logic funcInit,
    output logic debugInit,
    output logic simdInit,
    output logic wdogFlag,
    output logic coreRunning
);
    // RULE3 - Cluster power-on reset covers everything
    // Release is sampled only while gated, so the first ungated edge is shared
    always_ff @(posedge ref_clk) begin
        funcInit <= sys_rst || !coreRstN || !snoopRstN;
    end

    // RULE16 - Software reset keeps debug state
    always_ff @(posedge ref_clk) begin
        debugInit <= sys_rst || !debugRstN;
    end

    // RULE18 - SIMD reset touches engine only
    always_ff @(posedge ref_clk) begin
        simdInit <= sys_rst || !simdRstN || !coreRstN;
    end

    // RULE21 - Watchdog flag cleared independently
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !wdogRstN) begin
            wdogFlag <= 1'b0;
        end else if (wdogFire) begin
            wdogFlag <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        coreRunning <= !sys_rst && coreRstN && snoopRstN && !coreGate && !simdGate;
    end
endmodule : core_reset_slice

// ### rtl/cluster_reset_end.sv
// Device end: reset combinations as seen by the four-core cluster
`timescale 1ns/1ps
`include "reset_seq_defines.svh"

module cluster_reset_end (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Link
    reset_link_if.cluster link,
    // Watchdog events
    input wire logic [`NUM_CORES-1:0] wdogFire,
    // Status
    output logic [`NUM_CORES-1:0] funcInit_ff,
    output logic [`NUM_CORES-1:0] debugInit_ff,
    output logic [`NUM_CORES-1:0] simdInit_ff,
    output logic [`NUM_CORES-1:0] wdogFlag_ff,
    output logic [`NUM_CORES-1:0] coreRunning_ff,
    output logic sharedInit_ff
);
    logic [`NUM_CORES-1:0] funcInit;
    logic [`NUM_CORES-1:0] debugInit;
    logic [`NUM_CORES-1:0] simdInit;
    logic [`NUM_CORES-1:0] wdogFlag;
    logic [`NUM_CORES-1:0] coreRunning;

    // ==========================================================
    // Per-core slices
    // RULE13 - Per-core power-on resets core n
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_CORES; gi++) begin : g_core
            core_reset_slice u_slice (
                .ref_clk(ref_clk),
                .sys_rst(sys_rst),
                .snoopRstN(link.snoop_unit_rst_n),
                .coreRstN(link.core_rst_n[gi]),
                .simdRstN(link.simd_engine_rst_n[gi]),
                .debugRstN(link.debug_logic_rst_n[gi]),
                .wdogRstN(link.watchdog_flag_rst_n[gi]),
                .coreGate(link.core_clock_gate[gi]),
                .simdGate(link.simd_clock_gate[gi]),
                .wdogFire(wdogFire[gi]),
                .funcInit(funcInit[gi]),
                .debugInit(debugInit[gi]),
                .simdInit(simdInit[gi]),
                .wdogFlag(wdogFlag[gi]),
                .coreRunning(coreRunning[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Registered status
    // RULE11 - Cluster software reset spares debug
    always_ff @(posedge ref_clk) begin
        funcInit_ff <= funcInit;
        debugInit_ff <= debugInit;
        simdInit_ff <= simdInit;
        wdogFlag_ff <= wdogFlag;
        coreRunning_ff <= coreRunning;
    end

    // RULE19 - Debug reset affects debug only
    // RULE20 - Single-core debug reset
    always_ff @(posedge ref_clk) begin
        sharedInit_ff <= sys_rst || !link.snoop_unit_rst_n || !link.periph_block_rst_n;
    end
endmodule : cluster_reset_end

// ### dv/multicore_reset_sequencer_sva.sv
// Assertions on the reset link between controller and cluster
`timescale 1ns/1ps
`include "reset_seq_defines.svh"

module multicore_reset_sequencer_sva #(
    parameter int HOLD_CYCLES = `HOLD_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Link
    input wire logic snoop_unit_rst_n,
    input wire logic periph_block_rst_n,
    input wire logic [`NUM_CORES-1:0] core_rst_n,
    input wire logic [`NUM_CORES-1:0] simd_engine_rst_n,
    input wire logic [`NUM_CORES-1:0] debug_logic_rst_n,
    input wire logic [`NUM_CORES-1:0] watchdog_flag_rst_n,
    input wire logic [`NUM_CORES-1:0] core_clock_gate,
    input wire logic [`NUM_CORES-1:0] simd_clock_gate,
    input wire logic peripheral_clock_en
);
    localparam logic [`NUM_CORES-1:0] ALL1 = '1;
    logic inRst;
    logic anyGate;
    logic [7:0] holdCnt_ff;

    assign inRst = ((core_rst_n & simd_engine_rst_n) != ALL1);
    assign anyGate = ((core_clock_gate | simd_clock_gate) != '0);

    // Saturates so a long hold cannot wrap back below the minimum
    always_ff @(posedge ref_clk) begin
        if (sys_rst || !inRst) begin
            holdCnt_ff <= 8'h00;
        end else if (holdCnt_ff != 8'hFF) begin
            holdCnt_ff <= holdCnt_ff + 8'h01;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // ==========================================
    // Sequence steps
    sequence gatedHeld;
        (anyGate && inRst) [*8] ##1 (anyGate && inRst) [*2];
    endsequence
    sequence gatedReleased;
        (anyGate && !inRst) [*8] ##1 (anyGate && !inRst) [*2];
    endsequence
    sequence dbgHeld;
        $stable(debug_logic_rst_n) [*3];
    endsequence

    AST_HOLD_BEFORE_GATE: assert property ($rose(anyGate) |-> holdCnt_ff >= HOLD_CYCLES)
        else $error("clocks gated before reset hold elapsed");
    AST_SETTLE_AROUND_RELEASE: assert property ($rose(anyGate) |-> gatedHeld ##1 gatedReleased ##1 !anyGate)
        else $error("gate, release, ungate spacing wrong");
    AST_RELEASE_GATED: assert property ($past(inRst) && !inRst |-> anyGate)
        else $error("reset released with clocks running");
    // shared resets only for cluster kinds
    AST_SHARED_CLUSTER_ONLY: assert property (!snoop_unit_rst_n |-> core_rst_n == '0 && simd_engine_rst_n == '0
        && watchdog_flag_rst_n == '0 && (debug_logic_rst_n == '0 || debug_logic_rst_n == ALL1))
        else $error("shared reset with wrong companion resets");
    AST_SHARED_PAIR: assert property (snoop_unit_rst_n == periph_block_rst_n)
        else $error("snoop and peripheral resets differ");
    AST_PER_CORE_TARGET: assert property (snoop_unit_rst_n && core_rst_n != ALL1 |->
        $onehot(~core_rst_n) && simd_engine_rst_n == core_rst_n)
        else $error("per-core reset not on one core");
    AST_DEBUG_NO_GATE: assert property (debug_logic_rst_n != ALL1 && !inRst |-> !anyGate)
        else $error("clock gated during debug reset");
    AST_DEBUG_PULSE: assert property ($past(debug_logic_rst_n) == ALL1 && debug_logic_rst_n != ALL1 && !inRst
        |=> dbgHeld ##1 debug_logic_rst_n == ALL1)
        else $error("debug pulse length wrong");
    AST_WDOG_ALONE: assert property (watchdog_flag_rst_n != ALL1 && !inRst && debug_logic_rst_n == ALL1 |->
        $onehot(~watchdog_flag_rst_n) && snoop_unit_rst_n)
        else $error("watchdog reset not on one core alone");
    AST_PERIPH_RATIO: assert property (peripheral_clock_en |=> !peripheral_clock_en ##1 peripheral_clock_en)
        else $error("peripheral enable ratio wrong");
endmodule : multicore_reset_sequencer_sva

// ### dv/multicore_reset_sequencer_tb.sv
// Self-checking bench for the controller and cluster reset ends
`timescale 1ns/1ps
`include "reset_seq_defines.svh"

module multicore_reset_sequencer_tb;
    logic ref_clk;
    logic sys_rst;
    logic reqValid;
    reset_seq_pkg::reset_kind_type reqKind;
    logic [3:0] reqCore;
    logic reqWdog;
    logic busy_ff;
    logic done_ff;
    logic [3:0] wdogFire;
    logic [3:0] funcInit_ff;
    logic [3:0] debugInit_ff;
    logic [3:0] simdInit_ff;
    logic [3:0] wdogFlag_ff;
    logic [3:0] coreRunning_ff;
    logic sharedInit_ff;
    logic [16:0] linesNow;
    logic [7:0] gatesNow;
    logic [16:0] initNow;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;

    reset_link_if link();

    reset_controller_end #(.SIMD_PRESENT(1'h1), .HOLD_CYCLES(`HOLD_CYCLES), .SETTLE_CYCLES(`SETTLE_CYCLES))
        u_reset_controller_end (.ref_clk(ref_clk), .sys_rst(sys_rst), .reqValid(reqValid), .reqKind(reqKind),
        .reqCore(reqCore), .reqWdog(reqWdog), .busy_ff(busy_ff), .done_ff(done_ff), .link(link));
    cluster_reset_end u_cluster_reset_end (.ref_clk(ref_clk), .sys_rst(sys_rst), .link(link), .wdogFire(wdogFire),
        .funcInit_ff(funcInit_ff), .debugInit_ff(debugInit_ff), .simdInit_ff(simdInit_ff),
        .wdogFlag_ff(wdogFlag_ff), .coreRunning_ff(coreRunning_ff), .sharedInit_ff(sharedInit_ff));
    multicore_reset_sequencer_sva #(.HOLD_CYCLES(`HOLD_CYCLES)) u_multicore_reset_sequencer_sva (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .snoop_unit_rst_n(link.snoop_unit_rst_n),
        .periph_block_rst_n(link.periph_block_rst_n), .core_rst_n(link.core_rst_n),
        .simd_engine_rst_n(link.simd_engine_rst_n), .debug_logic_rst_n(link.debug_logic_rst_n),
        .watchdog_flag_rst_n(link.watchdog_flag_rst_n), .core_clock_gate(link.core_clock_gate),
        .simd_clock_gate(link.simd_clock_gate), .peripheral_clock_en(link.peripheral_clock_en));

    assign linesNow = {link.snoop_unit_rst_n, link.core_rst_n, link.simd_engine_rst_n, link.debug_logic_rst_n,
        link.watchdog_flag_rst_n};
    assign gatesNow = {link.core_clock_gate, link.simd_clock_gate};
    assign initNow = {~sharedInit_ff, ~funcInit_ff, ~simdInit_ff, ~debugInit_ff, coreRunning_ff};

    initial begin
        ref_clk = 1'h0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ==========================================
    // Helpers
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Hang guard, well above the longest expected run
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, cycles, 0);
            finish_test();
        end
    end

    // Expected link lines {shared, core, simd, debug, watchdog}
    function automatic logic [16:0] exp_lines(input reset_seq_pkg::reset_kind_type k, input logic [3:0] c,
        input logic w);
        case (k)
            reset_seq_pkg::KIND_CLUSTER_POR: return 17'h00000;
            reset_seq_pkg::KIND_CLUSTER_SW: return {1'h0, 4'h0, 4'h0, 4'hF, 4'h0};
            reset_seq_pkg::KIND_CORE_POR: return {1'h1, ~c, ~c, ~c, w ? ~c : 4'hF};
            reset_seq_pkg::KIND_CORE_SW: return {1'h1, ~c, ~c, 4'hF, w ? ~c : 4'hF};
            reset_seq_pkg::KIND_SIMD_POR: return {1'h1, 4'hF, ~c, 4'hF, 4'hF};
            reset_seq_pkg::KIND_CLUSTER_DBG: return {1'h1, 4'hF, 4'hF, 4'h0, 4'hF};
            reset_seq_pkg::KIND_CORE_DBG: return {1'h1, 4'hF, 4'hF, ~c, 4'hF};
            default: return {1'h1, 4'hF, 4'hF, 4'hF, ~c};
        endcase
    endfunction : exp_lines

    task automatic wait_idle();
        int k;
        k = 0;
        while (busy_ff !== 1'h0 && k < 200) begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        check(busy_ff, 1'h0);
    endtask : wait_idle

    task automatic reset_and_por();
        @(posedge ref_clk);
        sys_rst <= 1'h1;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'h0;
        wait_idle();
        check(wdogFlag_ff, 4'h0);
        check(linesNow, 17'h1FFFF);
        $display("Test power-on reset finished");
    endtask : reset_and_por

    task automatic fire_wdog();
        @(posedge ref_clk);
        wdogFire <= 4'hF;
        repeat (2) @(posedge ref_clk);
        wdogFire <= 4'h0;
        repeat (3) @(posedge ref_clk);
        #1;
        check(wdogFlag_ff, 4'hF);
    endtask : fire_wdog

    // One request; link and cluster sampled at fixed points of the walk
    task automatic run_req(input reset_seq_pkg::reset_kind_type k, input logic [3:0] c, input logic w,
        input logic [3:0] flags, input logic refuse);
        logic [16:0] lines;
        logic [7:0] gates;
        logic seqKind;
        int n;
        lines = exp_lines(k, c, w);
        seqKind = (k <= reset_seq_pkg::KIND_SIMD_POR);
        gates = (k <= reset_seq_pkg::KIND_CLUSTER_SW) ? 8'hFF :
            (k == reset_seq_pkg::KIND_SIMD_POR) ? {4'h0, c} : {c, c};
        wait_idle();
        @(posedge ref_clk);
        reqValid <= 1'h1;
        reqKind <= k;
        reqCore <= c;
        reqWdog <= w;
        n = -1;
        do begin
            @(posedge ref_clk);
            n++;
            // Second request while busy must be dropped
            reqValid <= refuse && (n == 4);
            #1;
            if (n == 1) check(linesNow, lines);
            if (n == 1) check(link.periph_block_rst_n, lines[16]);
            if (n == 3) check(initNow, {lines[16:4], lines[15:12]});
            if (n == 3) check(gatesNow, 8'h00);
            if (n == 16 && seqKind) check({gatesNow, linesNow}, {gates, lines});
            if (n == 26 && seqKind) check({gatesNow, linesNow}, {gates, 17'h1FFFF});
        end while (done_ff !== 1'h1 && n < 100);
        check(n, seqKind ? 36 : 5);
        check({gatesNow, linesNow}, {8'h00, 17'h1FFFF});
        check(wdogFlag_ff, flags);
        if (refuse) begin
            repeat (8) @(posedge ref_clk);
            #1;
            check(busy_ff, 1'h0);
        end
        $display("Test kind %0d core %h finished", k, c);
    endtask : run_req

    // ==========================================
    // Main sequence
    initial begin
        sys_rst = 1'h1;
        reqValid = 1'h0;
        reqKind = reset_seq_pkg::KIND_CLUSTER_POR;
        reqCore = 4'h0;
        reqWdog = 1'h0;
        wdogFire = 4'h0;
        reset_and_por();
        fire_wdog();
        run_req(reset_seq_pkg::KIND_CORE_DBG, 4'h2, 1'h0, 4'hF, 1'h1);
        run_req(reset_seq_pkg::KIND_CLUSTER_DBG, 4'h0, 1'h0, 4'hF, 1'h0);
        run_req(reset_seq_pkg::KIND_WDOG, 4'h4, 1'h0, 4'hB, 1'h0);
        run_req(reset_seq_pkg::KIND_CORE_POR, 4'h1, 1'h0, 4'hB, 1'h0);
        run_req(reset_seq_pkg::KIND_CORE_POR, 4'h1, 1'h1, 4'hA, 1'h0);
        run_req(reset_seq_pkg::KIND_CORE_SW, 4'h8, 1'h1, 4'h2, 1'h1);
        run_req(reset_seq_pkg::KIND_SIMD_POR, 4'h2, 1'h0, 4'h2, 1'h0);
        run_req(reset_seq_pkg::KIND_CLUSTER_SW, 4'h5, 1'h0, 4'h0, 1'h0);
        fire_wdog();
        run_req(reset_seq_pkg::KIND_CLUSTER_POR, 4'h3, 1'h0, 4'h0, 1'h0);
        fire_wdog();
        reset_and_por();
        finish_test();
    end
endmodule : multicore_reset_sequencer_tb
